// File: design/twc_pkg.sv
// shared constants, field layouts and types of the 8-bit wave timer
package twc_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PRESC_W = 10;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL_A  = 8'hb0;
  localparam logic [7:0] IDX_CTL_B  = 8'hb1;
  localparam logic [7:0] IDX_COUNT  = 8'hb2;
  localparam logic [7:0] IDX_CMP_A  = 8'hb3;
  localparam logic [7:0] IDX_CMP_B  = 8'hb4;
  localparam logic [7:0] IDX_FLAGS  = 8'hb5;
  localparam logic [7:0] IDX_CLKCFG = 8'hb6;

  localparam logic [ADDR_W-1:0] ADDR_CTL_A  = {IDX_CTL_A, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTL_B  = {IDX_CTL_B, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = {IDX_COUNT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CMP_A  = {IDX_CMP_A, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CMP_B  = {IDX_CMP_B, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FLAGS  = {IDX_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CLKCFG = {IDX_CLKCFG, 2'b00};

  // field positions
  localparam int unsigned CTLB_FORCE_A = 7;
  localparam int unsigned CTLB_FORCE_B = 6;
  localparam int unsigned FLAG_MATCH_B = 2;
  localparam int unsigned FLAG_MATCH_A = 1;
  localparam int unsigned FLAG_OVF     = 0;
  localparam int unsigned CLKCFG_ASYNC = 5;

  localparam logic [7:0] RESET_VAL  = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [7:0] COUNT_BOT  = 8'h00;

  typedef enum logic [2:0] {
    WM_NORMAL  = 3'b000,
    WM_PC_FF   = 3'b001,
    WM_CTC     = 3'b010,
    WM_FAST_FF = 3'b011,
    WM_RSVD4   = 3'b100,
    WM_PC_A    = 3'b101,
    WM_RSVD6   = 3'b110,
    WM_FAST_A  = 3'b111
  } twc_wave_mode_t;

  typedef enum logic [2:0] {
    CS_STOP    = 3'b000,
    CS_DIV1    = 3'b001,
    CS_DIV8    = 3'b010,
    CS_DIV32   = 3'b011,
    CS_DIV64   = 3'b100,
    CS_DIV128  = 3'b101,
    CS_DIV256  = 3'b110,
    CS_DIV1024 = 3'b111
  } twc_clk_sel_t;

  typedef enum logic [0:0] {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } twc_dir_t;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] rsvd;
    logic [1:0] wgm_lo;
  } twc_ctl_a_t;

  typedef struct packed {
    logic         force_a;
    logic         force_b;
    logic [1:0]   rsvd;
    logic         wgm_hi;
    twc_clk_sel_t cs;
  } twc_ctl_b_t;

endpackage

// File: design/twc_prescaler.sv
// prescaler: divides source ticks into the selected timer tick enable
`timescale 1ns/1ns
module twc_prescaler
  import twc_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic         src_tick_i,
  input  wire twc_clk_sel_t sel_i,
  output logic              tick_o
);

  logic [PRESC_W-1:0] div_q;
  logic [PRESC_W-1:0] div_d;

  // low bits that must all be set for one divided tick
  function automatic logic [PRESC_W-1:0] div_mask(input twc_clk_sel_t s);
    case (s)
      CS_DIV8:    div_mask = 10'h007;
      CS_DIV32:   div_mask = 10'h01f;
      CS_DIV64:   div_mask = 10'h03f;
      CS_DIV128:  div_mask = 10'h07f;
      CS_DIV256:  div_mask = 10'h0ff;
      CS_DIV1024: div_mask = 10'h3ff;
      default:    div_mask = 10'h000;
    endcase
  endfunction

  always_comb begin
    div_d = div_q;
    if (src_tick_i) begin
      div_d = div_q + 10'h001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_d;
    end
  end

  // stop code gives no tick at all
  always_comb begin
    if (sel_i == CS_STOP) begin
      tick_o = 1'b0;
    end else begin
      tick_o = src_tick_i && ((div_q & div_mask(sel_i)) == div_mask(sel_i));
    end
  end

endmodule

// File: design/twc_timer.sv
// 8-bit timer with two compare outputs, control and counter registers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
//
// Summary of operation
// - nonzero B action drives pin when direction set
// - non-PWM B: off, toggle, clear, set
// - fast PWM B: clear/set on match, reverse at bottom
// - fast PWM: level B at TOP acts at bottom
// - phase correct B: action flips with count direction
// - phase correct: level B at TOP acts at TOP
// - reserved control bits read as zero
// - three-bit waveform select picks mode
// - TOP source and compare load moment per mode
// - overflow flag moment per mode
// - force strobe applies output action in non-PWM
// - forced compare sets no flag, no clear
// - force bits read zero, inert in PWM
// - clock select divides source by 1 to 1024
// - select zero stops and holds counter
// - count value readable and writable directly
// - count write blocks match on next tick
// - equality compare only, no catch-up match
// - source clock internal or crystal pin
// - genuine B match sets flag, cleared by ack/one
module twc_timer
  import twc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              crystal_clock_i,
  input  wire logic              dir_a_i,
  input  wire logic              dir_b_i,
  input  wire logic              port_a_data_i,
  input  wire logic              port_b_data_i,
  input  wire logic [2:0]        flag_ack_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   pin_a_o,
  output logic                   pin_a_oe_o,
  output logic                   pin_b_o,
  output logic                   pin_b_oe_o
);

  twc_ctl_a_t     ctl_a_q, ctl_a_d;
  twc_ctl_b_t     ctl_b_q, ctl_b_d;
  logic [7:0]     cnt_q, cnt_d;
  logic [7:0]     cmp_a_buf_q, cmp_a_buf_d;
  logic [7:0]     cmp_b_buf_q, cmp_b_buf_d;
  logic [7:0]     cmp_a_q, cmp_a_d;
  logic [7:0]     cmp_b_q, cmp_b_d;
  logic [2:0]     flags_q, flags_d;
  logic           async_q, async_d;
  twc_dir_t       dir_q, dir_d;
  logic           block_q, block_d;
  logic           oc_a_q, oc_a_d;
  logic           oc_b_q, oc_b_d;
  logic           xtal_q;
  logic [7:0]     rdata_d;
  logic           pin_a_d, pin_b_d;

  twc_wave_mode_t mode;
  twc_wave_mode_t mode_w;
  logic [7:0]     top_val;
  logic           src_tick;
  logic           tick;
  logic           at_top;
  logic           hit_a, hit_b;
  logic           ovf;
  logic           force_a, force_b;
  logic           cnt_wr;
  logic [2:0]     flag_clr;

  function automatic logic is_pwm(input twc_wave_mode_t m);
    is_pwm = m[0];
  endfunction

  function automatic logic is_fast(input twc_wave_mode_t m);
    is_fast = (m[1:0] == 2'b11);
  endfunction

  // next compare output level for one channel
  function automatic logic wave_step(input logic cur, input logic [1:0] act,
                                     input twc_wave_mode_t m, input logic hit,
                                     input logic wrap, input logic down,
                                     input logic cmp_top, input logic tog_ok);
    logic r;
    r = cur;
    if (!is_pwm(m)) begin
      if (hit) begin
        case (act)
          2'b01:   r = ~cur;
          2'b10:   r = 1'b0;
          2'b11:   r = 1'b1;
          default: r = cur;
        endcase
      end
    end else if (act == 2'b01) begin
      if (tog_ok && hit) begin
        r = ~cur;
      end
    end else if (act[1]) begin
      if (hit && !cmp_top) begin
        r = act[0] ^ down;
      end
      if (is_fast(m) && wrap) begin
        r = ~act[0];
      end
      if (!is_fast(m) && wrap && cmp_top) begin
        r = ~act[0];
      end
    end
    return r;
  endfunction

  assign mode   = twc_wave_mode_t'({ctl_b_q.wgm_hi, ctl_a_q.wgm_lo});
  assign mode_w = twc_wave_mode_t'({wdata_i[3], ctl_a_q.wgm_lo});

  always_comb begin
    case (mode)
      WM_CTC, WM_PC_A, WM_FAST_A: top_val = cmp_a_q;
      default:                    top_val = COUNT_MAX;
    endcase
  end

  // internal clock ticks every cycle; crystal clock ticks on its rising edge
  assign src_tick = async_q ? (crystal_clock_i & ~xtal_q) : 1'b1;

  twc_prescaler u_presc (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .src_tick_i (src_tick),
    .sel_i      (ctl_b_q.cs),
    .tick_o     (tick)
  );

  assign cnt_wr  = wr_i && (addr_i == ADDR_COUNT);
  assign at_top  = tick && (cnt_q == top_val);
  // equality only: a skipped value is never caught up
  assign hit_a   = tick && !block_q && (cnt_q == cmp_a_q);
  assign hit_b   = tick && !block_q && (cnt_q == cmp_b_q);
  assign force_a = wr_i && (addr_i == ADDR_CTL_B) && wdata_i[CTLB_FORCE_A]
                   && !is_pwm(mode_w);
  assign force_b = wr_i && (addr_i == ADDR_CTL_B) && wdata_i[CTLB_FORCE_B]
                   && !is_pwm(mode_w);

  always_comb begin
    case (mode)
      WM_PC_FF, WM_PC_A: ovf = tick && (dir_q == DIR_DOWN) && (cnt_q == COUNT_BOT);
      WM_FAST_A:         ovf = at_top;
      default:           ovf = tick && (cnt_q == COUNT_MAX);
    endcase
  end

  // counter, direction and blocking
  always_comb begin
    cnt_d   = cnt_q;
    dir_d   = dir_q;
    block_d = block_q;
    if (tick) begin
      block_d = 1'b0;
      case (mode)
        WM_PC_FF, WM_PC_A: begin
          if (dir_q == DIR_UP) begin
            if (cnt_q == top_val) begin
              dir_d = DIR_DOWN;
              cnt_d = cnt_q - 8'h01;
            end else begin
              cnt_d = cnt_q + 8'h01;
            end
          end else begin
            if (cnt_q == COUNT_BOT) begin
              dir_d = DIR_UP;
              cnt_d = cnt_q + 8'h01;
            end else begin
              cnt_d = cnt_q - 8'h01;
            end
          end
        end
        WM_CTC, WM_FAST_FF, WM_FAST_A: begin
          cnt_d = (cnt_q == top_val) ? COUNT_BOT : cnt_q + 8'h01;
        end
        default: begin
          cnt_d = cnt_q + 8'h01;
        end
      endcase
    end
    if (!(mode == WM_PC_FF || mode == WM_PC_A)) begin
      dir_d = DIR_UP;
    end
    if (cnt_wr) begin
      cnt_d   = wdata_i;
      block_d = 1'b1;
    end
  end

  // registers written by software and compare buffers
  always_comb begin
    ctl_a_d     = ctl_a_q;
    ctl_b_d     = ctl_b_q;
    cmp_a_buf_d = cmp_a_buf_q;
    cmp_b_buf_d = cmp_b_buf_q;
    async_d     = async_q;
    flag_clr    = flag_ack_i;
    if (wr_i) begin
      case (addr_i)
        ADDR_CTL_A: begin
          ctl_a_d      = twc_ctl_a_t'(wdata_i);
          ctl_a_d.rsvd = 2'b00;
        end
        ADDR_CTL_B: begin
          ctl_b_d         = twc_ctl_b_t'(wdata_i);
          ctl_b_d.force_a = 1'b0;
          ctl_b_d.force_b = 1'b0;
          ctl_b_d.rsvd    = 2'b00;
        end
        ADDR_CMP_A:   cmp_a_buf_d = wdata_i;
        ADDR_CMP_B:   cmp_b_buf_d = wdata_i;
        ADDR_FLAGS:   flag_clr    = flag_ack_i | wdata_i[2:0];
        ADDR_CLKCFG:  async_d     = wdata_i[CLKCFG_ASYNC];
        default:      ctl_a_d     = ctl_a_q;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    flags_d = (flags_q & ~flag_clr) | {hit_b, hit_a, ovf};
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    if (!is_pwm(mode)) begin
      cmp_a_d = cmp_a_buf_d;
      cmp_b_d = cmp_b_buf_d;
    end else if (at_top) begin
      cmp_a_d = cmp_a_buf_q;
      cmp_b_d = cmp_b_buf_q;
    end
  end

  // waveform outputs and pin muxing
  always_comb begin
    oc_a_d  = wave_step(oc_a_q, ctl_a_q.act_a, mode, hit_a || force_a, at_top,
                        dir_q == DIR_DOWN, cmp_a_q == top_val, ctl_b_q.wgm_hi);
    oc_b_d  = wave_step(oc_b_q, ctl_a_q.act_b, mode, hit_b || force_b, at_top,
                        dir_q == DIR_DOWN, cmp_b_q == top_val, 1'b0);
    pin_a_d = (ctl_a_q.act_a != 2'b00) ? oc_a_q : port_a_data_i;
    pin_b_d = (ctl_a_q.act_b != 2'b00) ? oc_b_q : port_b_data_i;
  end

  // read data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ADDR_CTL_A:  rdata_d = {ctl_a_q.act_a, ctl_a_q.act_b, 2'b00, ctl_a_q.wgm_lo};
        ADDR_CTL_B:  rdata_d = {4'h0, ctl_b_q.wgm_hi, ctl_b_q.cs};
        ADDR_COUNT:  rdata_d = cnt_q;
        ADDR_CMP_A:  rdata_d = cmp_a_buf_q;
        ADDR_CMP_B:  rdata_d = cmp_b_buf_q;
        ADDR_FLAGS:  rdata_d = {5'h00, flags_q};
        ADDR_CLKCFG: rdata_d = {2'b00, async_q, 5'h00};
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctl_a_q     <= twc_ctl_a_t'(RESET_VAL);
      ctl_b_q     <= twc_ctl_b_t'(RESET_VAL);
      cnt_q       <= RESET_VAL;
      cmp_a_buf_q <= RESET_VAL;
      cmp_b_buf_q <= RESET_VAL;
      cmp_a_q     <= RESET_VAL;
      cmp_b_q     <= RESET_VAL;
      flags_q     <= 3'h0;
      async_q     <= 1'b0;
      dir_q       <= DIR_UP;
      block_q     <= 1'b0;
      oc_a_q      <= 1'b0;
      oc_b_q      <= 1'b0;
      xtal_q      <= 1'b0;
      rdata_o     <= 8'h00;
      pin_a_o     <= 1'b0;
      pin_a_oe_o  <= 1'b0;
      pin_b_o     <= 1'b0;
      pin_b_oe_o  <= 1'b0;
    end else begin
      ctl_a_q     <= ctl_a_d;
      ctl_b_q     <= ctl_b_d;
      cnt_q       <= cnt_d;
      cmp_a_buf_q <= cmp_a_buf_d;
      cmp_b_buf_q <= cmp_b_buf_d;
      cmp_a_q     <= cmp_a_d;
      cmp_b_q     <= cmp_b_d;
      flags_q     <= flags_d;
      async_q     <= async_d;
      dir_q       <= dir_d;
      block_q     <= block_d;
      oc_a_q      <= oc_a_d;
      oc_b_q      <= oc_b_d;
      xtal_q      <= crystal_clock_i;
      rdata_o     <= rdata_d;
      pin_a_o     <= pin_a_d;
      pin_a_oe_o  <= dir_a_i;
      pin_b_o     <= pin_b_d;
      pin_b_oe_o  <= dir_b_i;
    end
  end

  property p_pin_b_dir;
    @(posedge ref_clk_i) disable iff (reset_i)
      !reset_i |=> (pin_b_oe_o == $past(dir_b_i)) &&
                   (($past(ctl_a_q.act_b) == 2'b00) || (pin_b_o == $past(oc_b_q)));
  endproperty
  a_pin_b_dir: assert property (p_pin_b_dir) else $error("pin b drive wrong");

  property p_set_on_match;
    @(posedge ref_clk_i) disable iff (reset_i)
      (hit_b && !is_pwm(mode) && ctl_a_q.act_b == 2'b11) |=> oc_b_q ##1 pin_b_o;
  endproperty
  a_set_on_match: assert property (p_set_on_match) else $error("b not set on match");

  property p_fast_bottom;
    @(posedge ref_clk_i) disable iff (reset_i)
      (at_top && is_fast(mode) && ctl_a_q.act_b == 2'b10) |=> oc_b_q;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("b not set at bottom");

  property p_rsvd_zero;
    @(posedge ref_clk_i) disable iff (reset_i)
      (rd_i && addr_i == ADDR_CTL_A) |=> (rdata_o[3:2] == 2'b00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

  property p_ctc_top;
    @(posedge ref_clk_i) disable iff (reset_i)
      (at_top && mode == WM_CTC && !cnt_wr) |=> (cnt_q == COUNT_BOT);
  endproperty
  a_ctc_top: assert property (p_ctc_top) else $error("no clear at top");

  property p_ovf_normal;
    @(posedge ref_clk_i) disable iff (reset_i)
      (tick && mode == WM_NORMAL && cnt_q == COUNT_MAX) |=> flags_q[FLAG_OVF];
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("overflow not flagged");

  property p_force_noflag;
    @(posedge ref_clk_i) disable iff (reset_i)
      (force_b && !hit_b && !flags_q[FLAG_MATCH_B]) |=> !flags_q[FLAG_MATCH_B];
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force raised flag");

  property p_force_read_zero;
    @(posedge ref_clk_i) disable iff (reset_i)
      (rd_i && addr_i == ADDR_CTL_B) |=> (rdata_o[7:4] == 4'h0);
  endproperty
  a_force_read_zero: assert property (p_force_read_zero) else $error("force bits read");

  property p_stop_holds;
    @(posedge ref_clk_i) disable iff (reset_i)
      (ctl_b_q.cs == CS_STOP && !cnt_wr) |=> $stable(cnt_q);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

  property p_block;
    @(posedge ref_clk_i) disable iff (reset_i)
      cnt_wr ##1 (!cnt_wr && tick) |-> !hit_a && !hit_b;
  endproperty
  a_block: assert property (p_block) else $error("match after count write");

  property p_step;
    @(posedge ref_clk_i) disable iff (reset_i)
      (tick && mode == WM_NORMAL && !cnt_wr) |=> (cnt_q == $past(cnt_q) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

endmodule

// File: verification/tb_twc_timer.sv
// register-level self-checking testbench of the 8-bit wave timer
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module tb_twc_timer;
  import twc_pkg::*;
  logic              ref_clk_i;
  logic              reset_i;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_s;
  logic              rd_s;
  logic              xtal = 1'b0;
  logic              dir_b;
  logic              port_b;
  logic [2:0]        flag_ack;
  logic [DATA_W-1:0] rdata_o;
  logic              pin_a_o;
  logic              pin_a_oe_o;
  logic              pin_b_o;
  logic              pin_b_oe_o;
  logic [7:0]        d;
  int                err_total;
  int                samples_checked;
  int                cyc;
  int                divs[7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [1:0]        acts[4] = '{2'b10, 2'b11, 2'b01, 2'b01};
  logic              exps[4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  twc_timer uut (
    .addr_i         (addr),
    .wdata_i        (wdata),
    .wr_i           (wr_s),
    .rd_i           (rd_s),
    .ref_clk_i      (ref_clk_i),
    .reset_i        (reset_i),
    .crystal_clock_i(xtal),
    .dir_a_i        (dir_b),
    .dir_b_i        (dir_b),
    .port_a_data_i  (1'b0),
    .port_b_data_i  (port_b),
    .flag_ack_i     (flag_ack),
    .rdata_o        (rdata_o),
    .pin_a_o        (pin_a_o),
    .pin_a_oe_o     (pin_a_oe_o),
    .pin_b_o        (pin_b_o),
    .pin_b_oe_o     (pin_b_oe_o)
  );

  initial ref_clk_i = 1'b0;
  always #4 ref_clk_i = ~ref_clk_i;

  // crystal pin: one rising edge every 8 clock cycles
  always @(posedge ref_clk_i) begin
    xtal <= cyc[2];
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge ref_clk_i);
    wr_s <= 1'b0;
  endtask

  // read data stand in the cycle after the strobe only
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_i);
    rd_s <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  // two count samples 2*div cycles apart differ by exactly two ticks
  task automatic rate(input logic [2:0] cs, input int div);
    logic [7:0] c0;
    logic [7:0] c1;
    wr(ADDR_CTL_B, {5'h00, cs});
    rd(ADDR_COUNT, c0);
    idle(2 * div - 2);
    rd(ADDR_COUNT, c1);
    `CHK(8'(c1 - c0), 8'h02)
    wr(ADDR_CTL_B, 8'h00);
  endtask

  // counts high cycles of pin B over one settled period
  task automatic pwm_row(input logic [2:0] m, input logic [7:0] cmp, input logic [1:0] act,
                         input int per, input int hi);
    int n;
    n = 0;
    wr(ADDR_CTL_B, 8'h00);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CMP_A, 8'h3f);
    wr(ADDR_CMP_B, cmp);
    wr(ADDR_CTL_A, {2'b00, act, 2'b00, m[1:0]});
    wr(ADDR_CTL_B, {4'h0, m[2], 3'b001}); // force bits kept zero in PWM
    idle(3 * per);
    repeat (per) begin
      @(posedge ref_clk_i);
      #1;
      if (pin_b_o === 1'b1) n++;
    end
    `CHK(n, hi)
  endtask

  initial begin
    err_total = 0;
    samples_checked = 0;
    reset_i = 1'b1;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    dir_b = 1'b1;
    port_b = 1'b0;
    flag_ack = 3'b000;
    idle(10);
    reset_i <= 1'b0;
    rd(ADDR_CTL_A, d);
    `CHK(d, RESET_VAL)
    rd(ADDR_CTL_B, d);
    `CHK(d, RESET_VAL)
    rd(ADDR_COUNT, d);
    `CHK(d, RESET_VAL)
    wr(10'h3fc, 8'hff);
    rd(10'h3fc, d);
    `CHK(d, 8'h00)
    wr(ADDR_CTL_A, 8'hff);
    rd(ADDR_CTL_A, d);
    `CHK(d, 8'hf3)
    wr(ADDR_CTL_A, 8'h00);
    wr(ADDR_CTL_B, 8'hf0);
    rd(ADDR_CTL_B, d);
    `CHK(d, 8'h00)
    wr(ADDR_COUNT, 8'h5a);
    idle(20);
    rd(ADDR_COUNT, d);
    `CHK(d, 8'h5a)
    for (int i = 0; i < 7; i++) rate(3'(i + 1), divs[i]);
    wr(ADDR_CLKCFG, 8'h20);
    rate(3'b001, 8);
    wr(ADDR_CLKCFG, 8'h00);
    // port data reaches the pin while the action field is zero
    port_b <= 1'b1;
    idle(3);
    #1;
    `CHK(pin_b_o, 1'b1)
    `CHK(pin_b_oe_o, 1'b1)
    `CHK(pin_a_oe_o, 1'b1)
    `CHK(pin_a_o, 1'b0)
    @(posedge ref_clk_i);
    port_b <= 1'b0;
    dir_b <= 1'b0;
    idle(3);
    #1;
    `CHK(pin_b_o, 1'b0)
    `CHK(pin_b_oe_o, 1'b0)
    `CHK(pin_a_oe_o, 1'b0)
    @(posedge ref_clk_i);
    dir_b <= 1'b1;
    port_b <= 1'b1;
    // count written onto the compare level: first tick must not match
    wr(ADDR_CMP_B, 8'h20);
    wr(ADDR_CTL_A, 8'h30);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_COUNT, 8'h20);
    wr(ADDR_CTL_B, 8'h01);
    idle(10);
    wr(ADDR_CTL_B, 8'h00);
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_MATCH_B], 1'b0)
    `CHK(pin_b_o, 1'b0)
    wr(ADDR_COUNT, 8'h1e);
    wr(ADDR_CTL_B, 8'h01);
    idle(10);
    wr(ADDR_CTL_B, 8'h00);
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_MATCH_B], 1'b1)
    `CHK(pin_b_o, 1'b1)
    @(posedge ref_clk_i);
    flag_ack <= 3'b100;
    @(posedge ref_clk_i);
    flag_ack <= 3'b000;
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_MATCH_B], 1'b0)
    // forced compares walk the clear, set and toggle action codes
    wr(ADDR_FLAGS, 8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTL_A, {2'b00, acts[i], 4'h0});
      wr(ADDR_CTL_B, 8'h40);
      idle(3);
      #1;
      `CHK(pin_b_o, exps[i])
    end
    rd(ADDR_FLAGS, d);
    `CHK(d, 8'h00)
    wr(ADDR_CTL_A, 8'hc2);
    wr(ADDR_CMP_A, 8'h33);
    wr(ADDR_COUNT, 8'h33);
    wr(ADDR_CTL_B, 8'h80);
    rd(ADDR_COUNT, d);
    `CHK(d, 8'h33)
    `CHK(pin_a_o, 1'b1)
    wr(ADDR_CTL_A, 8'h23);
    wr(ADDR_CTL_B, 8'h40);
    idle(3);
    #1;
    `CHK(pin_b_o, 1'b1)
    // overflow moment in normal, clear-on-match and phase correct modes
    wr(ADDR_CTL_A, 8'h00);
    wr(ADDR_COUNT, 8'hfa);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTL_B, 8'h01);
    idle(20);
    wr(ADDR_CTL_B, 8'h00);
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_OVF], 1'b1)
    wr(ADDR_FLAGS, 8'h01);
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_OVF], 1'b0)
    wr(ADDR_CTL_A, 8'h02);
    wr(ADDR_CMP_A, 8'h10);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTL_B, 8'h01);
    idle(300);
    rd(ADDR_COUNT, d);
    `CHK(d <= 8'h10, 1'b1)
    wr(ADDR_CTL_B, 8'h00);
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_OVF], 1'b0)
    wr(ADDR_CTL_A, 8'h01);
    wr(ADDR_COUNT, 8'h05);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTL_B, 8'h01);
    idle(5);
    wr(ADDR_CTL_B, 8'h00);
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_OVF], 1'b0)
    wr(ADDR_CTL_B, 8'h01);
    idle(520);
    wr(ADDR_CTL_B, 8'h00);
    rd(ADDR_FLAGS, d);
    `CHK(d[FLAG_OVF], 1'b1)
    pwm_row(3'd3, 8'h80, 2'b10, 256, 129);
    pwm_row(3'd3, 8'h80, 2'b11, 256, 127);
    pwm_row(3'd3, 8'hff, 2'b10, 256, 256);
    pwm_row(3'd1, 8'h40, 2'b10, 510, 128);
    pwm_row(3'd1, 8'h40, 2'b11, 510, 382);
    pwm_row(3'd1, 8'hff, 2'b10, 510, 510);
    pwm_row(3'd7, 8'h10, 2'b10, 64, 17);
    pwm_row(3'd5, 8'h10, 2'b10, 126, 32);
    conclude();
  end
endmodule
